// ===== rtl/fdm_monitor.sv
`timescale 1ns/1ps
module fdm_monitor #(
	parameter int CHANNELS = 4,
	parameter longint STUCK_LIMIT = fdm_pkg::STUCK_CYCLES,
	parameter longint TIMER_125MS = fdm_pkg::CYC_125MS,
	parameter longint TIMER_500MS = fdm_pkg::CYC_500MS,
	parameter longint TIMER_2S = fdm_pkg::CYC_2S,
	parameter longint TIMER_4S = fdm_pkg::CYC_4S
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// configuration command strobe with enable bits
	input wire logic config_write_in,
	input wire logic disconnect_detect_enable_in,
	input wire logic overtemp_detect_enable_in,
	input wire logic output_short_detect_enable_in,
	input wire logic flash_check_enable_in,
	input wire logic host_timer_enable_in,
	// tool-time settings
	input wire logic [1:0] timer_period_sel_in,
	input wire logic standby_on_second_overflow_in,
	// amplifier mode command
	input wire logic amplifier_mode_command_in,
	input wire logic amp_power_up_in,
	input wire logic class_d_select_in,
	// analog sensors
	input wire logic speaker_absent_in,
	input wire logic overtemp_reached_in,
	input wire logic short_sensed_in,
	input wire logic pwm_out_in,
	// flash events, one bit per channel
	input wire logic [CHANNELS-1:0] flash_data_error_in,
	input wire logic [CHANNELS-1:0] flash_range_error_in,
	// host commands
	input wire logic error_clear_command_in,
	input wire logic host_timer_clear_command_in,
	input wire logic status_output_select_command_in,
	input wire logic status_select_in,
	input wire logic recovery_counter_error_in,
	output logic [fdm_pkg::ERR_W-1:0] error_flags_out,
	output logic speaker_out_off_out,
	output logic amp_active_out,
	output logic [CHANNELS-1:0] channel_stop_out,
	output logic command_standby_out,
	output logic status_pin_a_out,
	output logic status_pin_b_out
);
	import fdm_pkg::*;

	// elaboration-time limits: the stuck counter is 16 bits, the timer 32 bits
	if (CHANNELS < 1 || CHANNELS > 16)
	begin : g_chk_channels
		$error("fdm_monitor: channel count out of range");
	end

	if (STUCK_LIMIT < 1 || STUCK_LIMIT > 64'sh000000000000FFFF)
	begin : g_chk_stuck
		$error("fdm_monitor: stuck limit does not fit its counter");
	end

	// overflow compares against limit minus one, so one cycle cannot work
	if (TIMER_125MS < 2 || TIMER_500MS < 2 || TIMER_2S < 2 || TIMER_4S < 2)
	begin : g_chk_period_low
		$error("fdm_monitor: host timer period too short");
	end

	if (TIMER_125MS > 64'sh00000000FFFFFFFF || TIMER_500MS > 64'sh00000000FFFFFFFF
		|| TIMER_2S > 64'sh00000000FFFFFFFF || TIMER_4S > 64'sh00000000FFFFFFFF)
	begin : g_chk_period_high
		$error("fdm_monitor: host timer period does not fit its counter");
	end

	logic en_disconnect;
	logic en_overtemp;
	logic en_short;
	logic en_flash;
	logic timer_running;
	logic [1:0] period_sel;
	logic standby_opt;
	logic amp_active;
	logic [ERR_W-1:0] flags;
	logic [ERR_W-1:0] next_flags;
	logic [ERR_W-1:0] set_ev;
	logic [ERR_W-1:0] clr_ev;
	logic [15:0] stuck_cnt;
	logic [31:0] timer_cnt;
	logic [31:0] timer_limit;
	logic overflow_seen;
	logic timer_cleared;
	logic status_sel;
	logic disconnect_pulse;
	logic stuck_hit;
	logic timer_ovf;
	logic standby_move;
	logic [CHANNELS-1:0] flash_hit;

	function automatic logic [31:0] period_cycles(input logic [1:0] sel);
		unique case (sel)
			PERIOD_125MS: period_cycles = 32'(TIMER_125MS);
			PERIOD_500MS: period_cycles = 32'(TIMER_500MS);
			PERIOD_2S: period_cycles = 32'(TIMER_2S);
			PERIOD_4S: period_cycles = 32'(TIMER_4S);
		endcase
	endfunction

	// per-channel flash fault; range faults count even with checking disabled
	function automatic logic [CHANNELS-1:0] flash_hits(input logic enable,
		input logic [CHANNELS-1:0] data_err, input logic [CHANNELS-1:0] range_err);
		flash_hits = ({CHANNELS{enable}} & data_err) | range_err;
	endfunction

	// a status pin lights while any flag is up and that pin is selected
	function automatic logic pin_lit(input logic [ERR_W-1:0] err, input logic sel,
		input logic pin);
		pin_lit = (|err) && (sel == pin);
	endfunction

	// configuration; standby move drops the detection enables but not the host timer or status select
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			en_disconnect <= 1'b0;
			en_overtemp <= 1'b0;
			en_short <= 1'b0;
			en_flash <= 1'b0;
			period_sel <= PERIOD_RESET;
			standby_opt <= 1'b0;
		end
		else if (standby_move)
		begin
			en_disconnect <= 1'b0;
			en_overtemp <= 1'b0;
			en_short <= 1'b0;
			en_flash <= 1'b0;
		end
		else if (config_write_in)
		begin
			en_disconnect <= disconnect_detect_enable_in;
			en_overtemp <= overtemp_detect_enable_in;
			en_short <= output_short_detect_enable_in;
			en_flash <= flash_check_enable_in;
			period_sel <= timer_period_sel_in;
			standby_opt <= standby_on_second_overflow_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			amp_active <= 1'b0;
		else if (amplifier_mode_command_in)
			amp_active <= amp_power_up_in;
	end

	// check only on the power-up command edge
	assign disconnect_pulse = en_disconnect && amplifier_mode_command_in && amp_power_up_in
		&& !amp_active && speaker_absent_in;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			stuck_cnt <= 16'h0000;
		else if (!(en_short && amp_active && class_d_select_in && pwm_out_in))
			stuck_cnt <= 16'h0000;
		else if (!stuck_hit)
			stuck_cnt <= stuck_cnt + 16'h0001;
	end
	assign stuck_hit = stuck_cnt >= 16'(STUCK_LIMIT);

	// once started, only reset stops the host timer
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			timer_running <= 1'b0;
		else if (config_write_in && host_timer_enable_in)
			timer_running <= 1'b1;
	end

	assign timer_limit = period_cycles(period_sel);
	// a clear on the last count wins: the host was still in time
	assign timer_ovf = timer_running && (timer_cnt == timer_limit - 32'h00000001)
		&& !host_timer_clear_command_in;
	// second overflow since the last timer clear
	assign standby_move = timer_ovf && overflow_seen && standby_opt;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			timer_cnt <= 32'h00000000;
		else if (!timer_running || host_timer_clear_command_in || timer_ovf)
			timer_cnt <= 32'h00000000;
		else
			timer_cnt <= timer_cnt + 32'h00000001;
	end

	// overflow history and timer-clear gating of the timer error flag
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			overflow_seen <= 1'b0;
		else if (host_timer_clear_command_in)
			overflow_seen <= 1'b0;
		else if (timer_ovf)
			overflow_seen <= 1'b1;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			timer_cleared <= 1'b0;
		else if (host_timer_clear_command_in)
			timer_cleared <= 1'b1;
		else if (timer_ovf || error_clear_command_in)
			timer_cleared <= 1'b0;
	end

	assign flash_hit = flash_hits(en_flash, flash_data_error_in, flash_range_error_in);

	// event sources per flag
	always_comb
	begin
		set_ev = ERR_RESET;
		set_ev[ERR_DISCONNECT_BIT] = disconnect_pulse;
		set_ev[ERR_OVERTEMP_BIT] = en_overtemp && overtemp_reached_in;
		set_ev[ERR_SHORT_BIT] = (en_short && amp_active && short_sensed_in) || stuck_hit;
		set_ev[ERR_FLASH_BIT] = |flash_hit;
		set_ev[ERR_TIMER_BIT] = timer_ovf && !overflow_seen;
		set_ev[ERR_RECOVERY_BIT] = recovery_counter_error_in;
		clr_ev = {ERR_W{error_clear_command_in}};
		clr_ev[ERR_TIMER_BIT] = error_clear_command_in && timer_cleared;
	end

	// sticky, set beats clear; standby keeps flags
	assign next_flags = (flags & ~clr_ev) | set_ev;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			flags <= ERR_RESET;
		else
			flags <= next_flags;
	end

	// status pin selection survives standby move
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			status_sel <= STATUS_SEL_RESET;
		else if (status_output_select_command_in)
			status_sel <= status_select_in;
	end

	// flags readable from the edge that stores them
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			error_flags_out <= ERR_RESET;
		else
			error_flags_out <= next_flags;
	end

	// both outputs off together while short flag set
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			speaker_out_off_out <= 1'b0;
		else
			speaker_out_off_out <= next_flags[ERR_SHORT_BIT];
	end

	// amplifier state, one cycle behind the internal copy
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			amp_active_out <= 1'b0;
		else
			amp_active_out <= amp_active;
	end

	for (genvar ch = 0; ch < CHANNELS; ch++)
	begin : g_stop
		always_ff @(posedge clk_sys_in or negedge resetn_in)
		begin
			if (!resetn_in)
				channel_stop_out[ch] <= 1'b0;
			else
				channel_stop_out[ch] <= flash_hit[ch];
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			command_standby_out <= 1'b0;
		else
			command_standby_out <= standby_move;
	end

	// route any error to the selected pin
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			status_pin_a_out <= 1'b0;
			status_pin_b_out <= 1'b0;
		end
		else
		begin
			status_pin_a_out <= pin_lit(next_flags, status_sel, STATUS_SEL_A);
			status_pin_b_out <= pin_lit(next_flags, status_sel, ~STATUS_SEL_A);
		end
	end
endmodule

// ===== rtl/fdm_pkg.sv
package fdm_pkg;
	// error flag positions in the error word
	localparam int ERR_W = 6;
	localparam int ERR_DISCONNECT_BIT = 0;
	localparam int ERR_OVERTEMP_BIT = 1;
	localparam int ERR_SHORT_BIT = 2;
	localparam int ERR_FLASH_BIT = 3;
	localparam int ERR_TIMER_BIT = 4;
	localparam int ERR_RECOVERY_BIT = 5;
	localparam logic [5:0] ERR_RESET = 6'h00;
	// host-timer period selector codes
	localparam logic [1:0] PERIOD_125MS = 2'h0;
	localparam logic [1:0] PERIOD_500MS = 2'h1;
	localparam logic [1:0] PERIOD_2S = 2'h2;
	localparam logic [1:0] PERIOD_4S = 2'h3;
	localparam logic [1:0] PERIOD_RESET = PERIOD_2S;
	// timing
	localparam longint CLK_HZ = 200000000;
	localparam longint STUCK_NS = 62500;
	localparam longint CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam longint STUCK_CYCLES = (STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint PERIOD_125MS_MS = 125;
	localparam longint PERIOD_500MS_MS = 500;
	localparam longint PERIOD_2S_MS = 2000;
	localparam longint PERIOD_4S_MS = 4000;
	localparam longint CYC_PER_MS = CLK_HZ / 1000;
	localparam longint CYC_125MS = PERIOD_125MS_MS * CYC_PER_MS;
	localparam longint CYC_500MS = PERIOD_500MS_MS * CYC_PER_MS;
	localparam longint CYC_2S = PERIOD_2S_MS * CYC_PER_MS;
	localparam longint CYC_4S = PERIOD_4S_MS * CYC_PER_MS;
	// status pin routing select
	localparam logic STATUS_SEL_A = 1'b0;
	localparam logic STATUS_SEL_RESET = STATUS_SEL_A;
endpackage

// ===== tb/fault_detection_monitor_tb_top.sv
`timescale 1ns/1ps
module fault_detection_monitor_tb_top;
	import fdm_pkg::*;
	logic clk_sys_in = 0, resetn_in = 0, cfg = 0, amc = 0, apu = 0, cd = 0, abs = 0;
	logic otr = 0, ssn = 0, pwm = 0, stby = 0, rce = 0;
	logic [4:0] en = 0;
	logic [1:0] per = 0;
	logic [3:0] fr = 0, fd = 0, stop;
	logic clr, tcl, scmd, sel, offo, act, cso, pa, pb;
	logic [5:0] fl;
	int err_count = 0, checked = 0, n;
	fdm_monitor #(.STUCK_LIMIT(8), .TIMER_125MS(20), .TIMER_500MS(40), .TIMER_2S(80),
		.TIMER_4S(160)) uut (.clk_sys_in, .resetn_in, .config_write_in(cfg),
		.disconnect_detect_enable_in(en[0]), .overtemp_detect_enable_in(en[1]),
		.output_short_detect_enable_in(en[2]), .flash_check_enable_in(en[3]),
		.host_timer_enable_in(en[4]), .timer_period_sel_in(per),
		.standby_on_second_overflow_in(stby), .amplifier_mode_command_in(amc),
		.amp_power_up_in(apu), .class_d_select_in(cd), .speaker_absent_in(abs),
		.overtemp_reached_in(otr), .short_sensed_in(ssn), .pwm_out_in(pwm),
		.flash_data_error_in(fd), .flash_range_error_in(fr), .error_clear_command_in(clr),
		.host_timer_clear_command_in(tcl), .status_output_select_command_in(scmd),
		.status_select_in(sel), .recovery_counter_error_in(rce), .error_flags_out(fl),
		.speaker_out_off_out(offo), .amp_active_out(act), .channel_stop_out(stop),
		.command_standby_out(cso), .status_pin_a_out(pa), .status_pin_b_out(pb));
	fdm_host_model u_host (.clk_in(clk_sys_in), .clear_out(clr), .timer_clear_out(tcl),
		.select_cmd_out(scmd), .select_out(sel));
	initial
	begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	task tick(input int k = 1);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run();
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task configure(input logic [4:0] e, input logic [1:0] p);
		{en, per, stby, cfg} = {e, p, 2'h3};
		tick();
		cfg = 0;
	endtask
	task amp(input logic up);
		{apu, amc} = {up, 1'b1};
		tick();
		amc = 0;
		tick();
	endtask
	task wait_hi(input logic w);
		n = 0;
		while ((w ? cso : fl[4]) !== 1'b1 && n < 200)
		begin
			tick();
			n++;
		end
		if (n == 200)
		begin
			err_count++;
			complete_run();
		end
	endtask
	task t_temp();
		configure(5'h02, PERIOD_2S);
		u_host.select(1'b1);
		otr = 1;
		tick();
		otr = 0;
		chk({fl, pa, pb}, 16'h0009);
		tick(3);
		chk(fl, 16'h0002);
		u_host.clear_errors();
		chk({fl, pa, pb}, 16'h0000);
		configure(5'h00, PERIOD_2S);
		otr = 1;
		tick(2);
		otr = 0;
		chk(fl, 16'h0000);
	endtask
	task t_amp();
		configure(5'h05, PERIOD_2S);
		abs = 1;
		amp(1); // power-up right after configuration
		abs = 0;
		chk({fl, act}, 16'h0003);
		{cd, pwm} = 2'h3;
		tick(7);
		pwm = 0;
		tick();
		chk(fl, 16'h0001);
		pwm = 1;
		tick(10);
		pwm = 0;
		chk({fl, offo}, 16'h000B);
		amp(0);
		u_host.clear_errors();
		amp(1);
		ssn = 1;
		tick();
		ssn = 0;
		chk({fl, offo}, 16'h0009);
		amp(0);
		u_host.clear_errors();
		ssn = 1;
		tick();
		ssn = 0;
		chk({fl, act}, 16'h0000);
		fr = 4'h4;
		tick();
		fr = 4'h0;
		chk({fl, stop}, 16'h0084);
		// data errors are ignored while flash checking is off
		fd = 4'h2;
		tick();
		fd = 4'h0;
		chk({fl, stop}, 16'h0080);
		configure(5'h08, PERIOD_2S);
		fd = 4'h2;
		tick();
		fd = 4'h0;
		chk({fl, stop}, 16'h0082);
		// host reinitialises through the reset pin in mid-run
		resetn_in = 0;
		tick(2);
		chk({fl, stop, cso, pa, pb, offo, act}, 16'h0000);
		resetn_in = 1;
		tick(2);
		chk({fl, stop, cso, pa, pb, offo, act}, 16'h0000);
	endtask
	task t_timer();
		u_host.select(1'b1);
		configure(5'h10, PERIOD_125MS);
		configure(5'h00, PERIOD_125MS);
		wait_hi(1'b0);
		chk(n > 16 && n < 22, 16'h0001);
		u_host.clear_errors();
		chk(fl, 16'h0010);
		rce = 1;
		tick();
		rce = 0;
		wait_hi(1'b1);
		chk(n < 22, 16'h0001);
		chk({fl, pb}, 16'h0061);
		u_host.timer_clear();
		u_host.clear_errors();
		chk(fl, 16'h0000);
	endtask
	initial
	begin
		tick(6);
		resetn_in = 1;
		tick();
		t_temp();
		t_amp();
		t_timer();
		complete_run();
	end
endmodule

// ===== tb/fdm_checker.sv
`timescale 1ns/1ps
module fdm_checker #(
	parameter int CHANNELS = 4
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic amplifier_mode_command_in,
	input wire logic [CHANNELS-1:0] flash_range_error_in,
	input wire logic error_clear_command_in,
	input wire logic host_timer_clear_command_in,
	input wire logic [fdm_pkg::ERR_W-1:0] error_flags_out,
	input wire logic speaker_out_off_out,
	input wire logic [CHANNELS-1:0] channel_stop_out,
	input wire logic command_standby_out,
	input wire logic status_pin_a_out,
	input wire logic status_pin_b_out
);
	import fdm_pkg::*;
	logic tcl_seen;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// forgotten on error clear or when the timer flag rises
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			tcl_seen <= 1'b0;
		else if (host_timer_clear_command_in)
			tcl_seen <= 1'b1;
		else if (error_clear_command_in || $rose(error_flags_out[ERR_TIMER_BIT]))
			tcl_seen <= 1'b0;
	end
	property p_off;
		speaker_out_off_out == error_flags_out[ERR_SHORT_BIT];
	endproperty
	a_off: assert property (p_off) else $error("outputs off mismatch");
	property p_sticky;
		!error_clear_command_in |=>
			(error_flags_out & $past(error_flags_out)) == $past(error_flags_out);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_dc_clr;
		error_clear_command_in && !amplifier_mode_command_in
			|=> !error_flags_out[ERR_DISCONNECT_BIT];
	endproperty
	a_dc_clr: assert property (p_dc_clr) else $error("flag not cleared");
	property p_range;
		|flash_range_error_in |=> error_flags_out[ERR_FLASH_BIT] &&
			(channel_stop_out & $past(flash_range_error_in)) == $past(flash_range_error_in);
	endproperty
	a_range: assert property (p_range) else $error("range error ignored");
	property p_stop;
		|channel_stop_out |-> error_flags_out[ERR_FLASH_BIT];
	endproperty
	a_stop: assert property (p_stop) else $error("stop without flag");
	property p_pins;
		(|error_flags_out) == (status_pin_a_out ^ status_pin_b_out);
	endproperty
	a_pins: assert property (p_pins) else $error("status pins wrong");
	property p_stby;
		command_standby_out |-> error_flags_out[ERR_TIMER_BIT] ##1 !command_standby_out;
	endproperty
	a_stby: assert property (p_stby) else $error("standby pulse wrong");
	property p_tclr;
		error_clear_command_in && !host_timer_clear_command_in && !tcl_seen
			&& error_flags_out[ERR_TIMER_BIT] |=> error_flags_out[ERR_TIMER_BIT];
	endproperty
	a_tclr: assert property (p_tclr) else $error("timer flag cleared early");
endmodule
bind fdm_monitor fdm_checker #(.CHANNELS(CHANNELS)) u_chk (.clk_sys_in, .resetn_in,
	.amplifier_mode_command_in, .flash_range_error_in, .error_clear_command_in,
	.host_timer_clear_command_in, .error_flags_out, .speaker_out_off_out,
	.channel_stop_out, .command_standby_out, .status_pin_a_out, .status_pin_b_out);

// ===== tb/fdm_host_model.sv
`timescale 1ns/1ps
module fdm_host_model (
	input wire logic clk_in,
	output logic clear_out,
	output logic timer_clear_out,
	output logic select_cmd_out,
	output logic select_out
);
	initial {clear_out, timer_clear_out, select_cmd_out, select_out} = 4'h0;
	task clear_errors();
		@(posedge clk_in) #1 clear_out = 1'b1;
		@(posedge clk_in) #1 clear_out = 1'b0;
	endtask
	task timer_clear();
		@(posedge clk_in) #1 timer_clear_out = 1'b1;
		@(posedge clk_in) #1 timer_clear_out = 1'b0;
	endtask
	task select(input logic b);
		@(posedge clk_in) #1 {select_cmd_out, select_out} = {1'b1, b};
		@(posedge clk_in) #1 select_cmd_out = 1'b0;
	endtask
endmodule
